/* File: logic/csl_cfg.svh */
// offsets, field positions, reset values and timing figures of the coupler status block
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CSL_ADDR_W 8
`define CSL_OFF_CTRL 8'h00
`define CSL_OFF_STATION 8'h04
`define CSL_OFF_SAVED_IP 8'h08
`define CSL_OFF_EFF_IP 8'h0C
`define CSL_OFF_LED 8'h10
`define CSL_OFF_EVENT 8'h14
`define CSL_OFF_LINK 8'h18

// ****************************************
// control register fields
// ****************************************
`define CSL_CTRL_SYS_LSB 0
`define CSL_CTRL_DIAGNOSTIC_LED_LSB 4
`define CSL_CTRL_ONLINE 8
`define CSL_CTRL_CONN_DONE 9
`define CSL_CTRL_MAC_OK 10
`define CSL_CTRL_TIMEOUT 11
`define CSL_CTRL_SERIOUS 12
`define CSL_CTRL_ADV100 16
`define CSL_CTRL_RESET 32'h0001_0003

// ****************************************
// status and event fields
// ****************************************
`define CSL_STN_SAVED_BIT 8
`define CSL_EVT_SWCHG 0

// ****************************************
// reset values
// ****************************************
`define CSL_SAVED_IP_RESET 32'hC0A8_0203
`define CSL_STATION_NONE 8'h00

// ****************************************
// timing
// ****************************************
`define CSL_CLK_HZ 50000000
`define CSL_FLASH_MS 200
`define CSL_FLASH_CYC ((`CSL_CLK_HZ / 1000) * `CSL_FLASH_MS)
`define CSL_PATT_SLOTS 10

`endif

/* File: logic/csl_pkg.sv */
// types of the coupler status block
package csl_pkg;

  typedef enum logic [2:0] {
    CSL_SYS_OFF = 3'h0,
    CSL_SYS_WAIT = 3'h1,
    CSL_SYS_ONLINE = 3'h2,
    CSL_SYS_INIT = 3'h3,
    CSL_SYS_INIT_FAIL = 3'h4,
    CSL_SYS_RUN_FAIL = 3'h5,
    CSL_SYS_FW_MISMATCH = 3'h6,
    CSL_SYS_NET_INIT_FAIL = 3'h7
  } csl_sys_mode_t;

  typedef enum logic [2:0] {
    CSL_DIAGNOSTIC_LED_OFF = 3'h0,
    CSL_DIAGNOSTIC_LED_RUN = 3'h1,
    CSL_DIAGNOSTIC_LED_HOTSWAP = 3'h2,
    CSL_DIAGNOSTIC_LED_BUS_DOWN = 3'h3,
    CSL_DIAGNOSTIC_LED_NO_MODULE = 3'h4,
    CSL_DIAGNOSTIC_LED_BAD_MODULE = 3'h5,
    CSL_DIAGNOSTIC_LED_OVERSIZE = 3'h6,
    CSL_DIAGNOSTIC_LED_MISMATCH = 3'h7
  } csl_diagnostic_led_mode_t;

  typedef enum logic [1:0] {
    CSL_CAP = 2'b01,
    CSL_RUN = 2'b10
  } csl_cap_state_t;

endpackage

/* File: logic/csl_blink.sv */
// flash rate divider and counted blink patterns for the status indicators
`timescale 1ns/1ps
`default_nettype none
`include "csl_cfg.svh"

module csl_blink #(
  parameter int unsigned FLASH_CYC = `CSL_FLASH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic flash_q,
  output logic [3:0] patt_q
);

  localparam int unsigned CW = $clog2(FLASH_CYC + 1);
  localparam logic [3:0] SLOT_LAST = 4'(`CSL_PATT_SLOTS - 1);

  logic [CW-1:0] div_q;
  logic tick;
  logic [3:0] slot_q;

  // ****************************************
  // divider: one-cycle tick per flash half period
  // ****************************************
  assign tick = (div_q == CW'(FLASH_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= 4'h0;
      flash_q <= 1'b0;
    end else if (tick) begin
      flash_q <= ~flash_q;
      slot_q <= (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
    end
  end

  // ****************************************
  // pattern n: n+1 flashes, then a pause
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      patt_q <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        patt_q[n] <= (slot_q < 4'((n + 1) * 2)) && !slot_q[0];
      end
    end
  end

endmodule
`default_nettype wire

/* File: logic/csl_top.sv */
// station number capture, status indicator drive and register slave of the coupler
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csl_cfg.svh"

module csl_top #(
  parameter int unsigned FLASH_CYC = `CSL_FLASH_CYC,
  parameter logic [31:0] SAVED_IP_RESET = `CSL_SAVED_IP_RESET
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CSL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] station_high_digit_switch,
  input wire logic [3:0] station_low_digit_switch,
  input wire logic supply_ok,
  input wire logic io_supply_ok,
  input wire logic net_power_ok,
  input wire logic an_complete,
  input wire logic partner_100,
  output logic power_led,
  output logic system_led_green,
  output logic system_led_red,
  output logic diagnostic_led_green,
  output logic diagnostic_led_red,
  output logic io_power_led,
  output logic network_state_led_green,
  output logic network_state_led_red,
  output logic [31:0] ip_addr,
  output logic link_up,
  output logic link_speed_100
);

  // ****************************************
  // declarations
  // ****************************************
  csl_pkg::csl_cap_state_t cap_q;
  logic [7:0] station_q;
  logic [7:0] switch_now;
  logic [31:0] ctrl_q;
  logic [31:0] saved_ip_q;
  logic sw_changed_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic flash;
  logic [3:0] patt;
  csl_pkg::csl_sys_mode_t sys_mode;
  csl_pkg::csl_diagnostic_led_mode_t diagnostic_led_mode;
  logic online;
  logic conn_done;
  logic mac_ok;
  logic net_timeout;
  logic net_serious;
  logic sys_g_d;
  logic sys_r_d;
  logic diagnostic_led_g_d;
  logic diagnostic_led_r_d;
  logic net_g_d;
  logic net_r_d;
  logic [31:0] ip_d;
  logic sys_g_q;
  logic sys_r_q;
  logic diagnostic_led_g_q;
  logic diagnostic_led_r_q;
  logic net_g_q;
  logic net_r_q;
  logic pwr_q;
  logic iopwr_q;
  logic [31:0] ip_q;
  logic link_up_q;
  logic spd100_q;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_addr(input logic [`CSL_ADDR_W-1:0] a,
                                   input logic [`CSL_ADDR_W-1:0] off);
    is_addr = (a == off);
  endfunction

  function automatic logic fixed_or_flash(input logic steady, input logic blink,
                                          input logic phase);
    fixed_or_flash = steady | (blink & phase);
  endfunction

  // ****************************************
  // flash and pattern source
  // ****************************************
  csl_blink #(
    .FLASH_CYC(FLASH_CYC)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .flash_q(flash),
    .patt_q(patt)
  );

  // ****************************************
  // station number capture
  // ****************************************
  assign switch_now = {station_high_digit_switch, station_low_digit_switch};

  // first clocked cycle after release takes the switches, then never again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= csl_pkg::CSL_CAP;
      station_q <= `CSL_STATION_NONE;
    end else begin
      unique case (cap_q)
        csl_pkg::CSL_CAP: begin
          station_q <= switch_now;
          cap_q <= csl_pkg::CSL_RUN;
        end
        csl_pkg::CSL_RUN: begin
          cap_q <= csl_pkg::CSL_RUN;
        end
        default: begin
          cap_q <= csl_pkg::CSL_CAP;
        end
      endcase
    end
  end

  // a running change is only flagged, never applied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_changed_q <= 1'b0;
    end else if (cap_q == csl_pkg::CSL_RUN && switch_now != station_q) begin
      sw_changed_q <= 1'b1;
    end else if (wr_en && is_addr(paddr, `CSL_OFF_EVENT) && pwdata[`CSL_EVT_SWCHG]) begin
      sw_changed_q <= 1'b0;
    end
  end

  // ****************************************
  // address selection
  // ****************************************
  always_comb begin
    if (station_q == `CSL_STATION_NONE) begin
      ip_d = saved_ip_q;
    end else begin
      ip_d = {saved_ip_q[31:8], station_q};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip_q <= `CSL_SAVED_IP_RESET;
    end else begin
      ip_q <= ip_d;
    end
  end

  assign ip_addr = ip_q;

  // ****************************************
  // apb slave
  // ****************************************
  assign mapped = is_addr(paddr, `CSL_OFF_CTRL) | is_addr(paddr, `CSL_OFF_STATION) |
                  is_addr(paddr, `CSL_OFF_SAVED_IP) | is_addr(paddr, `CSL_OFF_EFF_IP) |
                  is_addr(paddr, `CSL_OFF_LED) | is_addr(paddr, `CSL_OFF_EVENT) |
                  is_addr(paddr, `CSL_OFF_LINK);
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CSL_CTRL_RESET;
    end else if (wr_en && is_addr(paddr, `CSL_OFF_CTRL)) begin
      ctrl_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_ip_q <= SAVED_IP_RESET;
    end else if (wr_en && is_addr(paddr, `CSL_OFF_SAVED_IP)) begin
      saved_ip_q <= pwdata;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_addr(paddr, `CSL_OFF_CTRL)) begin
      rd_mux = ctrl_q;
    end else if (is_addr(paddr, `CSL_OFF_STATION)) begin
      rd_mux[7:0] = station_q;
      rd_mux[`CSL_STN_SAVED_BIT] = (station_q == `CSL_STATION_NONE);
    end else if (is_addr(paddr, `CSL_OFF_SAVED_IP)) begin
      rd_mux = saved_ip_q;
    end else if (is_addr(paddr, `CSL_OFF_EFF_IP)) begin
      rd_mux = ip_q;
    end else if (is_addr(paddr, `CSL_OFF_LED)) begin
      rd_mux[7:0] = {net_r_q, net_g_q, iopwr_q, diagnostic_led_r_q, diagnostic_led_g_q, sys_r_q, sys_g_q, pwr_q};
    end else if (is_addr(paddr, `CSL_OFF_EVENT)) begin
      rd_mux[`CSL_EVT_SWCHG] = sw_changed_q;
    end else if (is_addr(paddr, `CSL_OFF_LINK)) begin
      rd_mux[1:0] = {spd100_q, link_up_q};
    end
  end

  // read data settles in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ****************************************
  // control field decode
  // ****************************************
  assign sys_mode = csl_pkg::csl_sys_mode_t'(ctrl_q[`CSL_CTRL_SYS_LSB +: 3]);
  assign diagnostic_led_mode = csl_pkg::csl_diagnostic_led_mode_t'(ctrl_q[`CSL_CTRL_DIAGNOSTIC_LED_LSB +: 3]);
  assign online = ctrl_q[`CSL_CTRL_ONLINE] & net_power_ok;
  assign conn_done = ctrl_q[`CSL_CTRL_CONN_DONE];
  assign mac_ok = ctrl_q[`CSL_CTRL_MAC_OK];
  assign net_timeout = ctrl_q[`CSL_CTRL_TIMEOUT];
  assign net_serious = ctrl_q[`CSL_CTRL_SERIOUS];

  // ****************************************
  // system indicator
  // ****************************************
  always_comb begin
    sys_g_d = 1'b0;
    sys_r_d = 1'b0;
    unique case (sys_mode)
      csl_pkg::CSL_SYS_OFF: begin
        sys_g_d = 1'b0;
      end
      csl_pkg::CSL_SYS_WAIT: begin
        sys_g_d = flash;
      end
      csl_pkg::CSL_SYS_ONLINE: begin
        sys_g_d = 1'b1;
      end
      csl_pkg::CSL_SYS_INIT: begin
        sys_r_d = flash;
      end
      csl_pkg::CSL_SYS_INIT_FAIL: begin
        sys_r_d = 1'b1;
      end
      csl_pkg::CSL_SYS_RUN_FAIL: begin
        sys_r_d = 1'b1;
      end
      csl_pkg::CSL_SYS_FW_MISMATCH: begin
        sys_r_d = 1'b1;
      end
      csl_pkg::CSL_SYS_NET_INIT_FAIL: begin
        sys_r_d = flash;
      end
    endcase
    // running switch change: flash red unless a fault already holds it steady
    if (sw_changed_q && !sys_r_d) begin
      sys_r_d = flash;
      sys_g_d = 1'b0;
    end
  end

  // ****************************************
  // diagnostic indicator
  // ****************************************
  always_comb begin
    diagnostic_led_g_d = 1'b0;
    diagnostic_led_r_d = 1'b0;
    unique case (diagnostic_led_mode)
      csl_pkg::CSL_DIAGNOSTIC_LED_OFF: begin
        diagnostic_led_g_d = 1'b0;
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_RUN: begin
        diagnostic_led_g_d = 1'b1;
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_HOTSWAP: begin
        diagnostic_led_g_d = flash;
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_BUS_DOWN: begin
        diagnostic_led_r_d = 1'b1;
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_NO_MODULE: begin
        diagnostic_led_r_d = patt[1];
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_BAD_MODULE: begin
        diagnostic_led_r_d = patt[2];
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_OVERSIZE: begin
        diagnostic_led_r_d = patt[3];
      end
      csl_pkg::CSL_DIAGNOSTIC_LED_MISMATCH: begin
        diagnostic_led_r_d = flash;
      end
    endcase
  end

  // ****************************************
  // network indicator
  // ****************************************
  always_comb begin
    net_g_d = 1'b0;
    net_r_d = 1'b0;
    if (online) begin
      net_g_d = fixed_or_flash(conn_done, ~conn_done, flash);
    end
    if (online && mac_ok) begin
      net_r_d = fixed_or_flash(net_serious, net_timeout, flash);
    end
  end

  // ****************************************
  // indicator outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= 1'b0;
      iopwr_q <= 1'b0;
    end else begin
      pwr_q <= supply_ok;
      iopwr_q <= io_supply_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_g_q <= 1'b0;
      sys_r_q <= 1'b0;
      diagnostic_led_g_q <= 1'b0;
      diagnostic_led_r_q <= 1'b0;
      net_g_q <= 1'b0;
      net_r_q <= 1'b0;
    end else begin
      sys_g_q <= sys_g_d & supply_ok;
      sys_r_q <= sys_r_d & supply_ok;
      diagnostic_led_g_q <= diagnostic_led_g_d & supply_ok;
      diagnostic_led_r_q <= diagnostic_led_r_d & supply_ok;
      net_g_q <= net_g_d & supply_ok;
      net_r_q <= net_r_d & supply_ok;
    end
  end

  assign power_led = pwr_q;
  assign io_power_led = iopwr_q;
  assign system_led_green = sys_g_q;
  assign system_led_red = sys_r_q;
  assign diagnostic_led_green = diagnostic_led_g_q;
  assign diagnostic_led_red = diagnostic_led_r_q;
  assign network_state_led_green = net_g_q;
  assign network_state_led_red = net_r_q;

  // ****************************************
  // link speed
  // ****************************************
  // 100 only when both ends offer it, else 10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_up_q <= 1'b0;
      spd100_q <= 1'b0;
    end else begin
      link_up_q <= an_complete;
      spd100_q <= an_complete & partner_100 & ctrl_q[`CSL_CTRL_ADV100];
    end
  end

  assign link_up = link_up_q;
  assign link_speed_100 = spd100_q;

endmodule
`default_nettype wire

/* File: test/csl_top_monitor.sv */
// port assertions of the coupler status block
`timescale 1ns/1ps
`default_nettype none
`include "csl_cfg.svh"

module csl_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [`CSL_ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] station_high_digit_switch,
  input wire logic [3:0] station_low_digit_switch,
  input wire logic supply_ok,
  input wire logic io_supply_ok,
  input wire logic net_power_ok,
  input wire logic an_complete,
  input wire logic partner_100,
  input wire logic power_led,
  input wire logic system_led_green,
  input wire logic system_led_red,
  input wire logic diagnostic_led_green,
  input wire logic diagnostic_led_red,
  input wire logic io_power_led,
  input wire logic network_state_led_green,
  input wire logic network_state_led_red,
  input wire logic [31:0] ip_addr,
  input wire logic link_up,
  input wire logic link_speed_100
);
  logic [1:0] age_q;
  logic [7:0] stn_q;
  // ****************************************
  // switch value seen at first edge after reset
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h2) begin
      age_q <= age_q + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stn_q <= 8'h00;
    end else if (age_q == 2'h0) begin
      stn_q <= {station_high_digit_switch, station_low_digit_switch};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_station_octet: assert property (age_q == 2'h2 && stn_q != 8'h00 |-> ip_addr[7:0] == stn_q)
    else $error("last octet differs from captured station");
  a_power_copy: assert property (presetn |=> power_led == $past(supply_ok))
    else $error("power lamp does not follow supply");
  a_io_copy: assert property (presetn |=> io_power_led == $past(io_supply_ok))
    else $error("io power lamp does not follow io supply");
  a_dark_unpowered: assert property (!supply_ok |=> !(system_led_green || system_led_red ||
    diagnostic_led_green || diagnostic_led_red || network_state_led_green ||
    network_state_led_red))
    else $error("lamp lit without supply");
  a_net_offline: assert property (!net_power_ok |=> !network_state_led_green && !network_state_led_red)
    else $error("network lamp lit without network power");
  a_link_follow: assert property ($changed(an_complete) |=> link_up == $past(an_complete))
    else $error("link up does not follow negotiation");
  a_speed_needs_up: assert property (!an_complete || !partner_100 |=> !link_speed_100)
    else $error("100 selected without partner offer");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_unmapped_err: assert property (psel && penable && paddr > `CSL_OFF_LINK |-> pslverr)
    else $error("no error on unmapped address");
  a_err_access_only: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
endmodule

bind csl_top csl_top_monitor csl_top_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .station_high_digit_switch(station_high_digit_switch),
  .station_low_digit_switch(station_low_digit_switch), .supply_ok(supply_ok),
  .io_supply_ok(io_supply_ok), .net_power_ok(net_power_ok), .an_complete(an_complete),
  .partner_100(partner_100), .power_led(power_led), .system_led_green(system_led_green),
  .system_led_red(system_led_red), .diagnostic_led_green(diagnostic_led_green),
  .diagnostic_led_red(diagnostic_led_red), .io_power_led(io_power_led),
  .network_state_led_green(network_state_led_green),
  .network_state_led_red(network_state_led_red), .ip_addr(ip_addr), .link_up(link_up),
  .link_speed_100(link_speed_100));
`default_nettype wire

/* File: test/csl_link_partner.sv */
// link partner model driving negotiation status toward the coupler
`timescale 1ns/1ps
`default_nettype none

module csl_link_partner #(
  parameter int unsigned AN_CYC = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic offer_100,
  output logic an_complete,
  output logic partner_100
);
  int unsigned wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 0;
    end else if (!start) begin
      wait_q <= 0;
    end else if (wait_q != AN_CYC) begin
      wait_q <= wait_q + 1;
    end
  end
  assign an_complete = (wait_q == AN_CYC);
  // no link: speed line keeps changing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_100 <= 1'b0;
    end else begin
      partner_100 <= an_complete ? offer_100 : ~partner_100;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench of the coupler status block
`timescale 1ns/1ps
`default_nettype none
`include "csl_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] sw_hi = 4'h0;
  logic [3:0] sw_lo = 4'h0;
  logic supply_ok = 1'b1;
  logic io_supply_ok = 1'b1;
  logic net_power_ok = 1'b1;
  logic link_start = 1'b0;
  logic offer_100 = 1'b0;
  logic [31:0] prdata, ip_addr, rd, saved;
  logic pready, pslverr, last_err, an_complete, partner_100, link_up, link_speed_100;
  logic power_led, sys_g, sys_r, diagnostic_led_g, diagnostic_led_r, io_power_led, net_g, net_r;
  logic [7:0] sws [5] = '{8'h12, 8'h00, 8'hFF, 8'h01, 8'h00};
  logic [4:0] nc [7] = '{5'h03, 5'h01, 5'h1F, 5'h15, 5'h0D, 5'h11, 5'h1E};
  int mismatches = 0;
  int n_compared = 0;
  int cnt [6];
  int unsigned seed;

  initial begin
    forever #10 pclk = ~pclk;
  end

  csl_top #(.FLASH_CYC(4)) csl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .station_high_digit_switch(sw_hi),
    .station_low_digit_switch(sw_lo), .supply_ok(supply_ok), .io_supply_ok(io_supply_ok),
    .net_power_ok(net_power_ok), .an_complete(an_complete), .partner_100(partner_100),
    .power_led(power_led), .system_led_green(sys_g), .system_led_red(sys_r),
    .diagnostic_led_green(diagnostic_led_g), .diagnostic_led_red(diagnostic_led_r), .io_power_led(io_power_led),
    .network_state_led_green(net_g), .network_state_led_red(net_r), .ip_addr(ip_addr),
    .link_up(link_up), .link_speed_100(link_speed_100));

  csl_link_partner #(.AN_CYC(16)) csl_link_partner_i (.pclk(pclk), .presetn(presetn),
    .start(link_start), .offer_100(offer_100), .an_complete(an_complete),
    .partner_100(partner_100));

  // ****************************************
  // bus cycles, measurement and expectations
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic power_up(input logic [7:0] sw);
    presetn <= 1'b0;
    sw_hi <= sw[7:4];
    sw_lo <= sw[3:0];
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic measure();
    logic [5:0] v;
    cnt = '{default: 0};
    repeat (3) @(posedge pclk);
    repeat (40) begin
      @(negedge pclk);
      v = {net_r, net_g, diagnostic_led_r, diagnostic_led_g, sys_r, sys_g};
      for (int j = 0; j < 6; j++)
        cnt[j] += (v[j] === 1'b1);
    end
    // hand back on a rising edge so the next stimulus lands there
    @(posedge pclk);
  endtask

  function automatic logic [31:0] exp_ip(logic [7:0] sw, logic [31:0] s);
    return (sw == 8'h00) ? s : {s[31:8], sw};
  endfunction

  // lit cycles in 40: steady 40, flash 20, pattern n gives 4(n+1)
  function automatic int exp_ones(int j, int s, int dg, logic [4:0] n, logic np);
    logic on;
    on = n[0] & np;
    case (j)
      0: return s == 2 ? 40 : s == 1 ? 20 : 0;
      1: return s inside {[4:6]} ? 40 : (s == 3 || s == 7) ? 20 : 0;
      2: return dg == 1 ? 40 : dg == 2 ? 20 : 0;
      3: return dg == 3 ? 40 : dg == 7 ? 20 : dg >= 4 ? 4 * (dg - 2) : 0;
      4: return (on & n[1]) ? 40 : on ? 20 : 0;
      default: return !(on & n[2]) ? 0 : n[4] ? 40 : n[3] ? 20 : 0;
    endcase
  endfunction

  task automatic mode_case(int s, int dg, logic [4:0] n, logic np);
    net_power_ok <= np;
    io_supply_ok <= 1'($urandom);
    apb(1'b1, `CSL_OFF_CTRL, {15'h0, 1'b1, 3'h0, n, 1'b0, 3'(dg), 1'b0, 3'(s)});
    measure();
    for (int j = 0; j < 6; j++)
      `CHK(cnt[j], exp_ones(j, s, dg, n, np))
    `CHK(io_power_led, io_supply_ok)
    `CHK(power_led, 1'b1)
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = $urandom(36);
    sws[4] = 8'($urandom_range(255, 2));
    foreach (sws[i]) begin
      power_up(sws[i]);
      saved = `CSL_SAVED_IP_RESET;
      if (i % 2 == 1) begin
        saved = $urandom;
        apb(1'b1, `CSL_OFF_SAVED_IP, saved);
      end
      repeat (3) @(posedge pclk);
      `CHK(ip_addr, exp_ip(sws[i], saved))
      apb(1'b0, `CSL_OFF_EFF_IP, 32'h0);
      `CHK(rd, exp_ip(sws[i], saved))
      apb(1'b0, `CSL_OFF_STATION, 32'h0);
      `CHK(rd, {23'h0, sws[i] == 8'h00, sws[i]})
    end
    apb(1'b0, `CSL_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0001_0003)
    apb(1'b1, `CSL_OFF_CTRL, 32'h0001_0002);
    sw_hi <= ~sw_hi;
    measure();
    `CHK(ip_addr, exp_ip(sws[4], saved))
    `CHK({cnt[0], cnt[1]}, {32'd0, 32'd20})
    apb(1'b0, `CSL_OFF_EVENT, 32'h0);
    `CHK(rd[0], 1'b1)
    sw_hi <= ~sw_hi;
    repeat (3) @(posedge pclk);
    apb(1'b1, `CSL_OFF_EVENT, 32'h1);
    apb(1'b0, `CSL_OFF_EVENT, 32'h0);
    `CHK(rd[0], 1'b0)
    apb(1'b1, 8'h1C, $urandom);
    `CHK(last_err, 1'b1)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({last_err, rd}, {1'b1, 32'h0})
    for (int m = 0; m < 8; m++)
      mode_case(m, 0, 5'h00, 1'b1);
    for (int m = 0; m < 8; m++)
      mode_case(0, m, 5'h00, 1'b1);
    foreach (nc[i])
      mode_case(2, 1, nc[i], i != 2);
    repeat (8)
      mode_case($urandom_range(7), $urandom_range(7), 5'($urandom), 1'($urandom));
    supply_ok <= 1'b0;
    measure();
    `CHK(cnt.sum(), 0)
    `CHK(power_led, 1'b0)
    supply_ok <= 1'b1;
    for (int a = 0; a < 3; a++) begin
      link_start <= 1'b0;
      offer_100 <= (a != 0);
      apb(1'b1, `CSL_OFF_CTRL, {15'h0, 1'(a < 2), 16'h0});
      link_start <= 1'b1;
      for (int k = 0; k < 100 && an_complete !== 1'b1; k++)
        @(posedge pclk);
      repeat (2) @(posedge pclk);
      apb(1'b0, `CSL_OFF_LINK, 32'h0);
      `CHK(rd[1:0], {a == 1, 1'b1})
      `CHK(link_speed_100, a == 1)
    end
    test_done();
  end
endmodule
`default_nettype wire
